// ---- rtl/prog_sel_pkg.sv ----
// Package for the cam program selection and output enable block.
// Assumes one clock domain at 125 MHz and an AXI4-Lite register bus.
package prog_sel_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_INPUTS = 32;
   localparam int NUM_OUTS = 32;
   localparam int NUM_CAMS = 32;
   localparam int PROG_W = 15;
   localparam int IDX_W = 5;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SELCFG = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASTER = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_MFLAGS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_SWAPPOS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CAMEDIT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_ACTPROG = 8'h1c;

   // ==========================================================
   // Field positions
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_MASTER_ON = 2;
   localparam int CTRL_SYSCFG = 3;
   localparam int CTRL_EN_LO = 8;
   localparam int SEL_TAKE_LO = 0;
   localparam int SEL_CNT_LO = 8;
   localparam int EDIT_CAM_LO = 0;
   localparam int EDIT_OUT_LO = 8;
   localparam int EDIT_VAL = 16;
   localparam int EDIT_PROG_LO = 17;

   // ==========================================================
   // Reset values and codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [5:0] EN_OFF = 6'h00;
   localparam logic [PROG_W-1:0] PROG_RST = 15'h0000;
   localparam logic [IDX_W-1:0] IDX_ZERO = 5'h00;

   // Change-over modes
   typedef enum logic [1:0] {
      MODE_SLOW = 2'h0,
      MODE_DIRECT = 2'h1,
      MODE_ON_POS = 2'h2
   } mode_t;

   // Build and swap states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_BUILD = 4'b0010,
      ST_WAIT_POS = 4'b0100,
      ST_SWAP = 4'b1000
   } state_t;

   // Write channel bundle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } wreq_t;
endpackage

// ---- rtl/prog_sel.sv ----
// Cam program selection, change-over and output enable gating.
// Assumes synchronous inputs on aclk, a per-program cam store outside
// reached by the stored-program index, and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none

module prog_sel
   import prog_sel_pkg::*;
#(
   parameter int NCAMS = NUM_CAMS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Machine inputs and position
   input wire logic [NUM_INPUTS-1:0] din,
   input wire logic [31:0] position,
   // Cam bit per output for active and master programs
   input wire logic [NUM_OUTS-1:0] cam_active,
   input wire logic [NUM_OUTS-1:0] cam_master,
   // Cam outputs and safety
   output logic [NUM_OUTS-1:0] cam_out,
   output logic safety_out,
   // Program used by the cam store for output and for edits
   output logic [PROG_W-1:0] store_prog,
   output logic store_bank,
   output logic edit_we,
   output logic [PROG_W-1:0] edit_prog,
   output logic [IDX_W-1:0] edit_out,
   output logic [IDX_W-1:0] edit_cam,
   output logic edit_val,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   // ==========================================================
   // State
   typedef struct packed {
      logic aw_held;
      logic w_held;
      wreq_t wr;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [1:0] mode;
      logic master_on;
      logic syscfg;
      logic [5:0] en_input;
      logic [5:0] take_input;
      logic [5:0] sel_count;
      logic [PROG_W-1:0] master_prog;
      logic [NUM_OUTS-1:0] master_flag;
      logic [31:0] swap_pos;
      logic [PROG_W-1:0] active_prog;
      logic [PROG_W-1:0] pending_prog;
      logic bank;
      state_t st;
      logic [IDX_W-1:0] cam_idx;
      logic take_prev;
      logic edit_we;
      logic [PROG_W-1:0] edit_prog;
      logic [IDX_W-1:0] edit_out;
      logic [IDX_W-1:0] edit_cam;
      logic edit_val;
      logic edit_refused;
      logic [NUM_OUTS-1:0] cam_out;
      logic safety;
   } state_all_t;

   state_all_t s;
   state_all_t next_s;

   // Bit of din at a 6-bit input number, zero when out of range
   function automatic logic input_bit(input logic [NUM_INPUTS-1:0] v, input logic [5:0] n);
      input_bit = (n < 6'(NUM_INPUTS)) ? v[n[IDX_W-1:0]] : 1'b0;
   endfunction

   // Register read mux
   function automatic logic [DATA_W-1:0] reg_read(input state_all_t c, input logic [ADDR_W-1:0] a);
      reg_read = '0;
      unique case (a)
         OFF_CTRL: reg_read = {16'h0000, 2'h0, c.en_input, 4'h0, c.syscfg, c.master_on, c.mode};
         OFF_SELCFG: reg_read = {16'h0000, 2'h0, c.sel_count, 2'h0, c.take_input};
         OFF_MASTER: reg_read = {17'h00000, c.master_prog};
         OFF_MFLAGS: reg_read = c.master_flag;
         OFF_SWAPPOS: reg_read = c.swap_pos;
         OFF_CAMEDIT: reg_read = {16'h0000, 15'h0000, c.edit_refused};
         OFF_STATUS: reg_read = {24'h000000, c.st, 1'b0, c.bank, c.safety, 1'b0};
         OFF_ACTPROG: reg_read = {17'h00000, c.active_prog};
         default: reg_read = '0;
      endcase
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a <= OFF_ACTPROG) && (a[1:0] == 2'b00);
   endfunction

   logic take_now;
   logic take_rise;
   logic [PROG_W-1:0] sel_num;
   logic gate_open;
   logic [NUM_OUTS-1:0] cam_src;

   // Decode selection inputs into a program number
   always_comb begin
      sel_num = PROG_RST;
      for (int i = 0; i < PROG_W; i++) begin
         if (6'(i) < s.sel_count) begin
            sel_num[i] = input_bit(din, 6'(s.take_input + 6'(i + 1)));
         end
      end
   end

   assign take_now = input_bit(din, s.take_input);
   assign take_rise = take_now && !s.take_prev;
   assign gate_open = (s.en_input == EN_OFF) || input_bit(din, s.en_input - 6'h01);

   // Per output cam source: master program, active program, or zero for unflagged outputs while the active program is the master program
   always_comb begin
      for (int o = 0; o < NUM_OUTS; o++) begin
         if (s.master_on && (s.master_flag[o] || s.active_prog == s.master_prog)) begin
            cam_src[o] = s.master_flag[o] && cam_master[o];
         end else begin
            cam_src[o] = cam_active[o];
         end
      end
   end

   // Next state
   always_comb begin
      next_s = s;
      next_s.take_prev = take_now;
      next_s.edit_we = 1'b0;
      next_s.cam_out = gate_open ? cam_src : '0;
      // Write address and data taken in either order
      if (awvalid && !s.aw_held) begin
         next_s.aw_held = 1'b1;
         next_s.wr.addr = awaddr;
      end
      if (wvalid && !s.w_held) begin
         next_s.w_held = 1'b1;
         next_s.wr.data = wdata;
      end
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.wr.addr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s.wr.addr)
            OFF_CTRL: begin
               next_s.mode = s.wr.data[CTRL_MODE_LO +: 2];
               next_s.master_on = s.wr.data[CTRL_MASTER_ON];
               next_s.syscfg = s.wr.data[CTRL_SYSCFG];
               next_s.en_input = s.wr.data[CTRL_EN_LO +: 6];
            end
            OFF_SELCFG: begin
               next_s.take_input = s.wr.data[SEL_TAKE_LO +: 6];
               next_s.sel_count = s.wr.data[SEL_CNT_LO +: 6];
            end
            OFF_MASTER: next_s.master_prog = s.wr.data[PROG_W-1:0];
            OFF_MFLAGS: next_s.master_flag = s.wr.data;
            OFF_SWAPPOS: next_s.swap_pos = s.wr.data;
            OFF_CAMEDIT: begin
               next_s.edit_out = s.wr.data[EDIT_OUT_LO +: IDX_W];
               next_s.edit_cam = s.wr.data[EDIT_CAM_LO +: IDX_W];
               next_s.edit_val = s.wr.data[EDIT_VAL];
               if (s.master_on && s.master_flag[s.wr.data[EDIT_OUT_LO +: IDX_W]]) begin
                  next_s.edit_prog = s.master_prog;
                  next_s.edit_we = s.syscfg;
                  next_s.edit_refused = !s.syscfg;
               end else begin
                  next_s.edit_prog = s.wr.data[EDIT_PROG_LO +: PROG_W];
                  next_s.edit_we = 1'b1;
                  next_s.edit_refused = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      // Read channel
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = reg_read(s, araddr);
         next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      // Program change-over
      unique case (s.st)
         ST_IDLE: begin
            if (take_rise) begin
               next_s.pending_prog = sel_num;
               next_s.cam_idx = IDX_ZERO;
               next_s.st = ST_BUILD;
               if (mode_t'(s.mode) == MODE_SLOW) begin
                  next_s.active_prog = sel_num;
                  next_s.safety = 1'b0;
               end
            end
         end
         ST_BUILD: begin
            next_s.cam_idx = s.cam_idx + 5'h01;
            if (s.cam_idx == 5'(NCAMS - 1)) begin
               if (mode_t'(s.mode) == MODE_SLOW) begin
                  next_s.st = ST_IDLE;
                  next_s.safety = 1'b1;
               end else if (mode_t'(s.mode) == MODE_ON_POS) begin
                  next_s.st = ST_WAIT_POS;
               end else begin
                  next_s.st = ST_SWAP;
               end
            end
         end
         ST_WAIT_POS: begin
            if (position > s.swap_pos) begin
               next_s.st = ST_SWAP;
            end
         end
         ST_SWAP: begin
            next_s.active_prog = s.pending_prog;
            next_s.bank = !s.bank;
            next_s.safety = 1'b1; // Recover if mode changed during a slow build
            next_s.st = ST_IDLE;
         end
      endcase
      if (!aresetn) begin
         next_s = '0;
         next_s.st = ST_IDLE;
         next_s.safety = 1'b1;
      end
   end

   // Register the whole state
   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   // Outputs
   assign cam_out = s.cam_out;
   assign safety_out = s.safety;
   assign store_prog = (s.st == ST_BUILD) ? s.pending_prog : s.active_prog;
   assign store_bank = (s.st == ST_IDLE || mode_t'(s.mode) == MODE_SLOW) ? s.bank : !s.bank;
   assign edit_we = s.edit_we;
   assign edit_prog = s.edit_prog;
   assign edit_out = s.edit_out;
   assign edit_cam = s.edit_cam;
   assign edit_val = s.edit_val;
   assign awready = !s.aw_held;
   assign wready = !s.w_held;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;

   // ==========================================================
   // Assertions
   gate_closed_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.en_input != EN_OFF && !input_bit(din, s.en_input - 6'h01)) |=> cam_out == '0)
      else $error("cam outputs active with enable low");
   gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.en_input == EN_OFF) |=> cam_out == $past(cam_src))
      else $error("cam outputs gated with gating off");
   take_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.st == ST_IDLE && take_rise) |=> s.pending_prog == $past(sel_num))
      else $error("program number not sampled on take-over");
   direct_safe_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_t'(s.mode) != MODE_SLOW && s.st == ST_IDLE && s.safety) |=> safety_out)
      else $error("safety dropped outside slow mode");
   slow_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_t'(s.mode) == MODE_SLOW && s.st == ST_IDLE && take_rise) |=> !safety_out)
      else $error("safety kept in slow change");
   pos_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.st == ST_WAIT_POS && position <= s.swap_pos) |=> s.st == ST_WAIT_POS)
      else $error("swap before position");
   master_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (gate_open && s.master_on && s.master_flag[0]) |=> cam_out[0] == $past(cam_master[0]))
      else $error("flagged output not from master");
   edit_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (edit_we && s.master_on && s.master_flag[edit_out]) |-> edit_prog == s.master_prog)
      else $error("master edit not redirected");
   edit_right_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.edit_refused |-> !edit_we)
      else $error("master edit done without right");
endmodule

`default_nettype wire

// ---- verif/sel_ctrl_model.sv ----
// Far-side machine controller: presents a program number, then a take-over pulse.
// Assumes a free-running aclk; the long hold times are scaled to HOLD cycles.
`timescale 1ns/1ps
`default_nettype none
module sel_ctrl_model #(
   parameter int HOLD = 16
) (
   // Clock and request from the bench
   input wire logic aclk,
   input wire logic go,
   input wire logic [14:0] prog,
   input wire logic [5:0] take_pos,
   input wire logic [5:0] sel_cnt,
   input wire logic [5:0] gate_pos,
   input wire logic gate_lvl,
   // Machine input lines and status
   output logic [31:0] din,
   output logic busy
);
   logic [31:0] lines;
   // Enable line laid over the other lines
   always_comb begin
      din = lines;
      din[gate_pos] = gate_lvl;
   end
   // Number first, pulse after the hold, then number lines driven to the inverted number
   initial begin
      lines = 32'h0;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (go) begin
            busy <= 1'b1;
            for (int i = 0; i < sel_cnt; i++) lines[take_pos + 1 + i] <= prog[i];
            repeat (HOLD) @(posedge aclk);
            lines[take_pos] <= 1'b1;
            repeat (HOLD) @(posedge aclk);
            lines[take_pos] <= 1'b0;
            for (int i = 0; i < sel_cnt; i++) lines[take_pos + 1 + i] <= ~prog[i];
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/test_prog_sel.sv ----
// Testbench for prog_sel: bus tasks, selection partner, model compare.
// Assumes the package, design and partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module test_prog_sel;
   import prog_sel_pkg::*;
   localparam int NC = 8;
   logic aclk, aresetn, go, gate_lvl, awvalid, wvalid, bready, arvalid, rready, busy;
   logic safety_out, store_bank, edit_we, edit_val, awready, wready, bvalid, arready, rvalid;
   logic [31:0] din, position, cam_active, cam_master, cam_out, wdata, rdata, d, fl;
   logic [PROG_W-1:0] store_prog, edit_prog, prog, e_prog;
   logic [IDX_W-1:0] edit_out, edit_cam, e_out, e_cam;
   logic e_val, bk;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int num_errors, samples_checked, drops, edits, n, act, mst, en, old, nw;
   int q[$];
   // ==========================================================
   // Design and far-side partner
   prog_sel #(.NCAMS(NC)) i_dut (.aclk(aclk), .aresetn(aresetn), .din(din),
      .position(position), .cam_active(cam_active), .cam_master(cam_master),
      .cam_out(cam_out), .safety_out(safety_out), .store_prog(store_prog),
      .store_bank(store_bank), .edit_we(edit_we), .edit_prog(edit_prog), .edit_out(edit_out),
      .edit_cam(edit_cam), .edit_val(edit_val), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   sel_ctrl_model i_ctrl (.aclk(aclk), .go(go), .prog(prog), .take_pos(6'h03),
      .sel_cnt(6'h04), .gate_pos(6'h14), .gate_lvl(gate_lvl), .din(din), .busy(busy));
   // Clock, safety drop and edit pulse watchers
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (aresetn === 1'b1 && safety_out === 1'b0) drops++;
      if (edit_we === 1'b1) begin
         edits++;
         e_prog <= edit_prog;
         e_out <= edit_out;
         e_cam <= edit_cam;
         e_val <= edit_val;
      end
   end
   // ==========================================================
   // Bus tasks: hold each channel until its ready is sampled
   task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] rr);
      logic ta, tw, done;
      int t;
      t = 0;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && t < 200) begin
         @(negedge aclk);
         ta = awvalid && awready === 1'b1;
         tw = wvalid && wready === 1'b1;
         done = bvalid === 1'b1;
         rr = bresp;
         t++;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end
      if (!done) num_errors++;
   endtask
   task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rr);
      logic ta, done;
      int t;
      t = 0;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && t < 200) begin
         @(negedge aclk);
         ta = arvalid && arready === 1'b1;
         done = rvalid === 1'b1;
         v = rdata;
         rr = rresp;
         t++;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end
      if (!done) num_errors++;
   endtask
   // Ask the partner for one take-over sequence and wait for it
   task automatic take(input logic [PROG_W-1:0] p);
      int t;
      t = 0;
      @(posedge aclk);
      prog <= p;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do begin
         @(negedge aclk);
         t++;
      end while (busy !== 1'b0 && t < 200);
   endtask
   // Expected cam outputs with master on
   function automatic logic [31:0] exp_cam(input logic [31:0] ca, cm, f, input int a, m, e,
                                           input logic lvl);
      logic [31:0] v;
      v = (cm & f) | ((a == m) ? 32'h0 : (ca & ~f));
      if (e != 0 && !lvl) v = 32'h0;
      return v;
   endfunction
   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {aresetn, go, gate_lvl, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {position, cam_active, cam_master, wdata, awaddr, araddr, prog} = '0;
      wstrb = 4'hf;
      void'($urandom(75671));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK(safety_out, 1'b1)
      `CHK(cam_out, 32'h0)
      axr(8'h40, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      axw(8'h42, 32'h1, r);
      `CHK(r, RESP_SLVERR)
      axw(OFF_SELCFG, 32'h0403, r);
      axw(OFF_SWAPPOS, 32'd100, r);
      old = 0;
      bk = 1'b0;
      for (int m = 0; m < 3; m++) begin
         axw(OFF_CTRL, 32'(m), r);
         nw = (old + 1 + $urandom % 15) % 16;
         q.push_back(nw);
         drops = 0;
         take(PROG_W'(nw));
         if (m == 2) begin
            axr(OFF_ACTPROG, d, r);
            `CHK(d, 32'(old))
            position <= 32'd101;
         end
         n = 0;
         do begin
            axr(OFF_ACTPROG, d, r);
            n++;
         end while (d !== 32'(nw) && n < 40);
         `CHK(d, 32'(q.pop_front()))
         `CHK(drops != 0, m == 0)
         bk = bk ^ (m != 0);
         @(negedge aclk);
         `CHK({store_bank, store_prog}, {bk, PROG_W'(nw)})
         position <= 32'd0;
         old = nw;
      end
      act = old;
      axr(OFF_STATUS, d, r);
      `CHK(d, 32'h12 | (32'(bk) << 2))
      axw(OFF_MASTER, 32'h7fff, r);
      axr(OFF_MASTER, d, r);
      `CHK(d, 32'h7fff)
      fl = $urandom;
      axw(OFF_MFLAGS, fl, r);
      for (int k = 0; k < 4; k++) begin
         en = (k == 0) ? 0 : 21;
         mst = (k == 3) ? act : 32767;
         gate_lvl <= k[0];
         axw(OFF_MASTER, 32'(mst), r);
         axw(OFF_CTRL, 32'(en << 8) | 32'h5, r);
         cam_active <= $urandom;
         cam_master <= $urandom;
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         `CHK(cam_out, exp_cam(cam_active, cam_master, fl, act, mst, en, gate_lvl))
      end
      axw(OFF_MASTER, 32'h7fff, r);
      axw(OFF_MFLAGS, 32'h20, r);
      axw(OFF_CTRL, 32'hd, r);
      edits = 0;
      axw(OFF_CAMEDIT, 32'(act << 17) | 32'h10502, r);
      repeat (3) @(posedge aclk);
      `CHK({edits, e_prog, e_out, e_cam, e_val}, {32'd1, 15'h7fff, 5'h05, 5'h02, 1'b1})
      axw(OFF_CTRL, 32'h5, r);
      axw(OFF_CAMEDIT, 32'(act << 17) | 32'h10502, r);
      axr(OFF_CAMEDIT, d, r);
      `CHK(d[0], 1'b1)
      axw(OFF_CAMEDIT, 32'(act << 17) | 32'h00603, r);
      repeat (3) @(posedge aclk);
      `CHK({edits, e_prog, e_out, e_cam, e_val}, {32'd2, PROG_W'(act), 5'h06, 5'h03, 1'b0})
      axr(OFF_CAMEDIT, d, r);
      `CHK(d[0], 1'b0)
      final_report();
   end
endmodule
`default_nettype wire
